// *** logic/fault_log_cfg.svh ***
// Constants for the fault log block formatter: offsets, record layout, timing.
`ifndef FAULT_LOG_CFG_SVH
`define FAULT_LOG_CFG_SVH
// Register byte addresses on the bus
`define FL_ADR_CTRL 12'h000
`define FL_ADR_STATUS 12'h004
`define FL_ADR_POINTER 12'h008
`define FL_ADR_VALID 12'h00C
`define FL_ADR_TS_CAP_LO 12'h010
`define FL_ADR_TS_CAP_HI 12'h014
`define FL_ADR_TS_NOW_LO 12'h018
`define FL_ADR_TS_NOW_HI 12'h01C
`define FL_ADR_MINMAX 12'h040
`define FL_ADR_MINMAX_END 12'h068
`define FL_ADR_STAT 12'h080
`define FL_ADR_STAT_END 12'h0A0
`define FL_ADR_LOOP 12'h400
`define FL_ADR_LOOP_END 12'h6E0
// Control fields
`define FL_CTRL_START_BIT 0
// Record storage sizes
`define FL_TS_BITS 41
`define FL_MM_BYTES 40
`define FL_STAT_BYTES 24
`define FL_LOOP_LAST 6'h2D
`define FL_LOOP_LEN 8'h2E
`define FL_LOOP_MEM 184
`define FL_LOOP_MEM_W 8'hB8
// Record byte positions
`define FL_REC_POINTER 8'h00
`define FL_REC_VALID 8'h01
`define FL_REC_TS 8'h02
`define FL_REC_MM 8'h08
`define FL_REC_STAT 8'h30
`define FL_REC_CYCLIC 8'h48
`define FL_REC_RESERVED 8'hEE
`define FL_REC_LAST 8'hFE
`define FL_BLOCK_COUNT 8'hFF
// Timestamp tick: 200 us at a 50 ns clock
`define FL_TICK_NS 200000
`define FL_CLK_NS 50
`define FL_TICK_CYCLES (`FL_TICK_NS / `FL_CLK_NS)
// Output buffer shape
`define FL_BUF_WIDTH 9
`define FL_BUF_DEPTH 2
`endif

// *** logic/fault_log_pkg.sv ***
// Types shared by the fault log block formatter.
package fault_log_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_COUNT,
		ST_RECORD
	} stream_state_e;
endpackage : fault_log_pkg

// *** logic/byte_buffer.sv ***
// Small shift FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic [DEPTH-1:0] vld_reg;
	logic [WIDTH-1:0] dat_reg [DEPTH];
	logic [DEPTH-1:0] up_vld;
	logic [WIDTH-1:0] up_dat [DEPTH];
	logic pop;
	logic push;

	// Entry 0 is always the head, so outputs come straight from flops
	assign pop = vld_reg[0] & out_ready_i;
	assign push = in_valid_i & ~vld_reg[DEPTH-1];
	assign in_ready_o = ~vld_reg[DEPTH-1];
	assign out_valid_o = vld_reg[0];
	assign out_data_o = dat_reg[0];

	////////////////////////////////////////////////////////////////////////
	// One entry per step: shift down on pop, fill lowest free slot on push
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			if (i == DEPTH - 1) begin : g_top
				assign up_vld[i] = 1'b0;
				assign up_dat[i] = '0;
			end else begin : g_mid
				assign up_vld[i] = vld_reg[i+1];
				assign up_dat[i] = dat_reg[i+1];
			end
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					vld_reg[i] <= 1'b0;
					dat_reg[i] <= '0;
				end else if (pop) begin
					if (up_vld[i]) begin
						vld_reg[i] <= 1'b1;
						dat_reg[i] <= up_dat[i];
					end else if (vld_reg[i] && push) begin
						dat_reg[i] <= in_data_i;
					end else begin
						vld_reg[i] <= 1'b0;
					end
				end else if (push && !vld_reg[i] && (i == 0 || vld_reg[(i == 0) ? 0 : i-1])) begin
					vld_reg[i] <= 1'b1;
					dat_reg[i] <= in_data_i;
				end
			end
		end
	endgenerate
endmodule : byte_buffer

// *** logic/fault_log_block_formatter.sv ***
// Fault log record store and block-read byte stream formatter.
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

// Overview of operation
// - Byte 0 carries stored loop pointer
// - Byte 1 carries count of valid cyclic bytes
// - Timestamp in six bytes, LSB first, top bit last
// - Timestamp counter ticks every 200 microseconds
// - Peak then minimum per source, low byte first
// - Three status bytes per channel, preamble ends 71
// - Cyclic loops of 46 bytes start at 72
// - Cyclic bytes start at pointer, descend
// - Loop positions map to fixed channel items
// - Pointer follows block byte count 0xFF
module fault_log_block_formatter (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic fault_i,
	output logic byte_valid_o,
	input wire logic byte_ready_i,
	output logic [7:0] byte_data_o,
	output logic byte_last_o
);
	fault_log_pkg::stream_state_e state_reg;
	logic ack_reg;
	logic [31:0] rd_reg;
	logic [31:0] rd_next;
	logic wb_req;
	logic wb_wr;
	logic [7:0] pointer_reg;
	logic [7:0] valid_reg;
	logic [7:0] mm_mem [`FL_MM_BYTES];
	logic [7:0] stat_mem [`FL_STAT_BYTES];
	logic [7:0] loop_mem [`FL_LOOP_MEM];
	logic [11:0] tick_reg;
	logic [`FL_TS_BITS-1:0] ts_now_reg;
	logic [`FL_TS_BITS-1:0] ts_cap_reg;
	logic fault_s1_reg;
	logic fault_s2_reg;
	logic fault_s3_reg;
	logic [7:0] rec_reg;
	logic [5:0] pos_reg;
	logic [7:0] base_reg;
	logic [7:0] loop_idx;
	logic [7:0] rec_byte;
	logic [47:0] ts_ext;
	logic [2:0] ts_sel;
	logic push_valid;
	logic push_ready;
	logic push_fire;
	logic [7:0] push_byte;
	logic push_last;
	logic mm_hit;
	logic stat_hit;
	logic loop_hit;
	logic [3:0] mm_word;
	logic [2:0] st_word;
	logic [4:0] st_base;
	logic [7:0] lp_word;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wb_wr = wb_req & wb_we_i;
	assign mm_hit = (wb_adr_i >= `FL_ADR_MINMAX) && (wb_adr_i < `FL_ADR_MINMAX_END) && (wb_adr_i[1:0] == 2'h0);
	assign stat_hit = (wb_adr_i >= `FL_ADR_STAT) && (wb_adr_i < `FL_ADR_STAT_END) && (wb_adr_i[1:0] == 2'h0);
	assign loop_hit = (wb_adr_i >= `FL_ADR_LOOP) && (wb_adr_i < `FL_ADR_LOOP_END) && (wb_adr_i[1:0] == 2'h0);
	assign mm_word = 4'((wb_adr_i - `FL_ADR_MINMAX) >> 2);
	assign st_word = 3'((wb_adr_i - `FL_ADR_STAT) >> 2);
	assign st_base = 5'({2'h0, st_word} * 5'h03);
	assign lp_word = 8'((wb_adr_i - `FL_ADR_LOOP) >> 2);
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rd_reg;

	// Single-cycle answer to every access, mapped or not
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_reg <= 1'b0;
			rd_reg <= 32'h00000000;
		end else begin
			ack_reg <= wb_req;
			rd_reg <= wb_req ? rd_next : 32'h00000000;
		end
	end

	// Read data selection; unmapped addresses read zero
	always_comb begin
		rd_next = 32'h00000000;
		case (wb_adr_i)
			`FL_ADR_STATUS: rd_next = {16'h0000, rec_reg, 7'h00, state_reg != fault_log_pkg::ST_IDLE};
			`FL_ADR_POINTER: rd_next = {24'h000000, pointer_reg};
			`FL_ADR_VALID: rd_next = {24'h000000, valid_reg};
			`FL_ADR_TS_CAP_LO: rd_next = ts_cap_reg[31:0];
			`FL_ADR_TS_CAP_HI: rd_next = {23'h000000, ts_cap_reg[40:32]};
			`FL_ADR_TS_NOW_LO: rd_next = ts_now_reg[31:0];
			`FL_ADR_TS_NOW_HI: rd_next = {23'h000000, ts_now_reg[40:32]};
			default: begin
				if (mm_hit) begin
					rd_next = {mm_mem[{mm_word, 2'h3}], mm_mem[{mm_word, 2'h2}],
						mm_mem[{mm_word, 2'h1}], mm_mem[{mm_word, 2'h0}]};
				end else if (stat_hit) begin
					rd_next = {8'h00, stat_mem[5'(st_base + 5'h02)], stat_mem[5'(st_base + 5'h01)], stat_mem[st_base]};
				end else if (loop_hit) begin
					rd_next = {24'h000000, loop_mem[lp_word]};
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Pointer and valid-count registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pointer_reg <= 8'h00;
			valid_reg <= 8'h00;
		end else if (wb_wr && wb_sel_i[0]) begin
			if (wb_adr_i == `FL_ADR_POINTER) begin
				pointer_reg <= wb_dat_i[7:0];
			end
			if (wb_adr_i == `FL_ADR_VALID) begin
				valid_reg <= wb_dat_i[7:0];
			end
		end
	end

	// Peak/minimum and status byte stores, one process per byte so no entry has two writers
	genvar e;
	generate
		for (e = 0; e < `FL_MM_BYTES; e++) begin : g_mm
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					mm_mem[e] <= 8'h00;
				end else if (wb_wr && mm_hit && mm_word == 4'(e / 4) && wb_sel_i[e % 4]) begin
					mm_mem[e] <= wb_dat_i[8*(e%4) +: 8];
				end
			end
		end
		for (e = 0; e < `FL_STAT_BYTES; e++) begin : g_st
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					stat_mem[e] <= 8'h00;
				end else if (wb_wr && stat_hit && st_word == 3'(e / 3) && wb_sel_i[e % 3]) begin
					stat_mem[e] <= wb_dat_i[8*(e%3) +: 8];
				end
			end
		end
	endgenerate

	// Cyclic loop store, indexed loop * 46 + position
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int k = 0; k < `FL_LOOP_MEM; k++) begin
				loop_mem[k] <= 8'h00;
			end
		end else if (wb_wr && loop_hit && wb_sel_i[0]) begin
			loop_mem[lp_word] <= wb_dat_i[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared timestamp counter, one count per 200 us
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_reg <= 12'h000;
			ts_now_reg <= '0;
		end else if (tick_reg == 12'(`FL_TICK_CYCLES - 1)) begin
			tick_reg <= 12'h000;
			ts_now_reg <= ts_now_reg + 41'h1;
		end else begin
			tick_reg <= tick_reg + 12'h001;
		end
	end

	// Fault pin synchroniser; rising edge captures the timestamp
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fault_s1_reg <= 1'b0;
			fault_s2_reg <= 1'b0;
			fault_s3_reg <= 1'b0;
			ts_cap_reg <= '0;
		end else begin
			fault_s1_reg <= fault_i;
			fault_s2_reg <= fault_s1_reg;
			fault_s3_reg <= fault_s2_reg;
			if (fault_s2_reg && !fault_s3_reg) begin
				ts_cap_reg <= ts_now_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Record byte selection by record position
	assign ts_ext = {7'h00, ts_cap_reg};
	assign ts_sel = 3'(rec_reg - `FL_REC_TS);
	assign loop_idx = 8'(base_reg + {2'h0, pos_reg});

	always_comb begin
		rec_byte = 8'h00;
		if (rec_reg == `FL_REC_POINTER) begin
			rec_byte = pointer_reg;
		end else if (rec_reg == `FL_REC_VALID) begin
			rec_byte = valid_reg;
		end else if (rec_reg < `FL_REC_MM) begin
			rec_byte = ts_ext[{ts_sel, 3'h0} +: 8];
		end else if (rec_reg < `FL_REC_STAT) begin
			rec_byte = mm_mem[6'(rec_reg - `FL_REC_MM)];
		end else if (rec_reg < `FL_REC_CYCLIC) begin
			rec_byte = stat_mem[5'(rec_reg - `FL_REC_STAT)];
		end else if (rec_reg < `FL_REC_RESERVED && loop_idx < `FL_LOOP_MEM_W) begin
			rec_byte = loop_mem[loop_idx];
		end
	end

	assign push_valid = state_reg != fault_log_pkg::ST_IDLE;
	assign push_fire = push_valid & push_ready;
	assign push_byte = (state_reg == fault_log_pkg::ST_COUNT) ? `FL_BLOCK_COUNT : rec_byte;
	assign push_last = (state_reg == fault_log_pkg::ST_RECORD) && (rec_reg == `FL_REC_LAST);

	// Stream sequencer: count byte, then 255 record bytes
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= fault_log_pkg::ST_IDLE;
			rec_reg <= 8'h00;
		end else begin
			case (state_reg)
				fault_log_pkg::ST_IDLE: begin
					if (wb_wr && wb_adr_i == `FL_ADR_CTRL && wb_sel_i[0] && wb_dat_i[`FL_CTRL_START_BIT]) begin
						state_reg <= fault_log_pkg::ST_COUNT;
						rec_reg <= `FL_REC_POINTER;
					end
				end
				fault_log_pkg::ST_COUNT: begin
					if (push_fire) begin
						state_reg <= fault_log_pkg::ST_RECORD;
					end
				end
				fault_log_pkg::ST_RECORD: begin
					if (push_fire) begin
						if (push_last) begin
							state_reg <= fault_log_pkg::ST_IDLE;
						end
						rec_reg <= 8'(rec_reg + 8'h01);
					end
				end
				default: state_reg <= fault_log_pkg::ST_IDLE;
			endcase
		end
	end

	// Loop walk: descend, wrap to 45 of the next stored loop
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pos_reg <= 6'h00;
			base_reg <= 8'h00;
		end else if (state_reg == fault_log_pkg::ST_COUNT) begin
			pos_reg <= pointer_reg[5:0];
			base_reg <= 8'h00;
		end else if (push_fire && rec_reg >= `FL_REC_CYCLIC && rec_reg < `FL_REC_RESERVED) begin
			if (pos_reg == 6'h00) begin
				pos_reg <= `FL_LOOP_LAST;
				base_reg <= 8'(base_reg + `FL_LOOP_LEN);
			end else begin
				pos_reg <= pos_reg - 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output buffer absorbs receiver stalls
	byte_buffer #(
		.WIDTH(`FL_BUF_WIDTH),
		.DEPTH(`FL_BUF_DEPTH)
	) u_buffer (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i({push_last, push_byte}),
		.out_valid_o(byte_valid_o),
		.out_ready_i(byte_ready_i),
		.out_data_o({byte_last_o, byte_data_o})
	);
endmodule : fault_log_block_formatter

// *** testbench/fault_log_block_formatter_properties.sv ***
// Checker of bus answers and stream framing for the fault log formatter.
`timescale 1ns/1ps
module fault_log_block_formatter_properties (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic byte_valid_o,
	input wire logic byte_ready_i,
	input wire logic [7:0] byte_data_o,
	input wire logic byte_last_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] pos_reg;
	// Index of the stream byte now offered
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pos_reg <= 8'h00;
		end else if (byte_valid_o && byte_ready_i) begin
			pos_reg <= pos_reg + 8'h01;
		end
	end
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero");
	a_byte_held: assert property (byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_data_o))
		else $error("stalled byte lost");
	a_count_first: assert property (byte_valid_o && pos_reg == 8'h00 |-> byte_data_o == 8'hFF)
		else $error("count byte wrong");
	a_last_marks_end: assert property (byte_valid_o |-> byte_last_o == (pos_reg == 8'hFF))
		else $error("last flag wrong");
	a_reserved_zero: assert property (byte_valid_o && pos_reg > 8'hEE |-> byte_data_o == 8'h00)
		else $error("reserved byte not zero");
	a_ts_top_bit: assert property (byte_valid_o && pos_reg == 8'h08 |-> byte_data_o[7:1] == 7'h00)
		else $error("timestamp top byte wide");
endmodule : fault_log_block_formatter_properties
////////////////////////////////////////////////////////////////////////////////
bind fault_log_block_formatter fault_log_block_formatter_properties u_props (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i),
	.byte_data_o(byte_data_o), .byte_last_o(byte_last_o));

// *** testbench/fault_log_reader.sv ***
// Block-read host model that accepts and stores the byte stream.
`timescale 1ns/1ps
module fault_log_reader (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic slow_i,
	input wire logic clear_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_data_i,
	output logic byte_ready_o,
	output logic [8:0] got_o
);
	logic [7:0] mem [0:255];
	logic [1:0] beat_reg;
	// Stall two cycles in three when slow
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			beat_reg <= 2'h0;
		end else begin
			beat_reg <= (beat_reg == 2'h2) ? 2'h0 : beat_reg + 2'h1;
		end
	end
	assign byte_ready_o = !slow_i || beat_reg == 2'h0;
	// Store each accepted byte
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			got_o <= 9'h000;
		end else if (clear_i) begin
			got_o <= 9'h000;
		end else if (byte_valid_i && byte_ready_o) begin
			mem[got_o[7:0]] <= byte_data_i;
			got_o <= got_o + 9'h001;
		end
	end
endmodule : fault_log_reader

// *** testbench/tb_fault_log_block_formatter.sv ***
// Self-checking bench: register setup, fault capture, three block reads.
`timescale 1ns/1ps
`include "fault_log_cfg.svh"
module tb_fault_log_block_formatter;
	logic clk_i, reset_n_i, cyc, stb, we, ack, fault, slow, clr, valid, ready, last;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [7:0] data;
	logic [8:0] got;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	int p;
	fault_log_block_formatter u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.fault_i(fault), .byte_valid_o(valid), .byte_ready_i(ready), .byte_data_o(data), .byte_last_o(last));
	fault_log_reader u_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .slow_i(slow), .clear_i(clr),
		.byte_valid_i(valid), .byte_data_i(data), .byte_ready_o(ready), .got_o(got));
	////////////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	// One classic Wishbone cycle
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	// Expected stream byte n for pointer ptr
	function automatic logic [7:0] exp_byte(input int n, input int ptr);
		int r, t, idx;
		r = n - 1;
		if (n == 0) return 8'hFF;
		if (r == 0) return 8'(ptr);
		if (r == 1) return 8'hA0;
		if (r == 2) return 8'h03;
		if (r >= 8 && r < 48) return 8'((32'hA1B2C3D4 + 32'h01010101 * ((r - 8) / 4)) >> (8 * ((r - 8) % 4)));
		if (r >= 48 && r < 72) return 8'((32'h0030A050 + 32'h00010101 * ((r - 48) / 3)) >> (8 * ((r - 48) % 3)));
		if (r >= 72 && r < 238) begin
			t = 45 - ptr + r - 72;
			idx = (t / 46) * 46 + 45 - t % 46;
			if (idx < 184) return 8'(idx) ^ 8'h5A;
		end
		return 8'h00;
	endfunction : exp_byte
	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			conclude();
		end
	end
	// Main sequence
	initial begin
		{cyc, stb, we, fault, slow, clr, reset_n_i} = 7'h00;
		adr = 12'h000;
		wdat = 32'h0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (12100) @(posedge clk_i);
		fault <= 1'b1;
		repeat (8) @(posedge clk_i);
		fault <= 1'b0;
		bus(1'b0, `FL_ADR_TS_CAP_LO, 32'h0, q);
		chk(q, 32'h3);
		bus(1'b0, 12'h7FC, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, `FL_ADR_VALID, 32'hA0, q);
		for (int i = 0; i < 10; i++) bus(1'b1, `FL_ADR_MINMAX + 12'(4 * i), 32'hA1B2C3D4 + 32'h01010101 * i, q);
		for (int i = 0; i < 8; i++) bus(1'b1, `FL_ADR_STAT + 12'(4 * i), 32'h0030A050 + 32'h00010101 * i, q);
		for (int i = 0; i < 184; i++) bus(1'b1, `FL_ADR_LOOP + 12'(4 * i), 32'(8'(i) ^ 8'h5A), q);
		for (int k = 0; k < 3; k++) begin
			p = (k == 0) ? 11 : ((k == 1) ? 45 : 0);
			slow <= (k == 1);
			bus(1'b1, `FL_ADR_POINTER, 32'(p), q);
			bus(1'b0, `FL_ADR_POINTER, 32'h0, q);
			chk(q, 32'(p));
			bus(1'b1, `FL_ADR_CTRL, 32'h1, q);
			wait (got == 9'h100);
			for (int n = 0; n < 256; n++) begin
				if (n < 3) chk(u_host.mem[n], exp_byte(n, p));
				else if (n < 9) chk(u_host.mem[n], exp_byte(n, p));
				else if (n < 49) chk(u_host.mem[n], exp_byte(n, p));
				else if (n < 73) chk(u_host.mem[n], exp_byte(n, p));
				else chk(u_host.mem[n], exp_byte(n, p));
			end
			clr <= 1'b1;
			@(posedge clk_i);
			clr <= 1'b0;
		end
		conclude();
	end
endmodule : tb_fault_log_block_formatter
